// ==== design/sool_pkg.sv ====
/*
 * Shared constants for the serial octal output latch.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package sool_pkg;
    localparam int          CHANNELS      = 8;
    localparam int          CNT_W         = 3;
    localparam int          REJ_W         = 3;
    localparam logic [2:0]  REJECT_LIMIT  = 3'h4;
    localparam logic [7:0]  SHIFT_RESET   = 8'h00;
    localparam logic [2:0]  SYNC_RESET    = 3'h0;
    localparam logic        OUT_OFF       = 1'b0;
    localparam logic        SO_RESET      = 1'b0;
endpackage

// ==== design/sool_chan_if.sv ====
/*
 * Carrier between the serial front end and the channel latches.
 * Assumes one clock shared by both ends.
 */
`timescale 1ns/100ps
`default_nettype none
interface sool_chan_if;
    logic       clk;
    logic       rst_b;
    logic       dis_n;
    logic       load;
    logic [7:0] data;
    logic       allow;
    modport ctrl (output clk, output rst_b, output dis_n, output load, output data,
                  output allow);
    modport chan (input clk, input rst_b, input dis_n, input load, input data,
                  input allow);
endinterface
`default_nettype wire

// ==== design/sool_chan.sv ====
/*
 * One channel: its own latch and the flip-flop that drives the power output.
 * Assumes dis_n is the raw disable pin, used as an asynchronous clear only.
 */
`timescale 1ns/100ps
`default_nettype none
module sool_chan #(
    parameter int IDX = 0            // channel number
) (
    sool_chan_if.chan bus,           // shared control
    output var logic  q              // power output of this channel
);
    import sool_pkg::*;

    typedef struct packed {
        logic held;
        logic drv;
    } sool_chan_type;

    sool_chan_type st;
    sool_chan_type next_st;

    always_comb begin
        next_st = st;
        if (bus.load) begin
            next_st.held = bus.data[IDX];
        end
        next_st.drv = next_st.held & bus.allow;
    end

    // disable pin clears without a clock edge
    always_ff @(posedge bus.clk or negedge bus.dis_n) begin
        if (!bus.dis_n) begin
            st <= '{held: OUT_OFF, drv: OUT_OFF};
        end else if (!bus.rst_b) begin
            st <= '{held: OUT_OFF, drv: OUT_OFF};
        end else begin
            st <= next_st;
        end
    end

    assign q = st.drv;
endmodule // sool_chan
`default_nettype wire

// ==== design/sool_top.sv ====
/*
 * Serial octal output latch: shift-register front end, frame check,
 * eight channel latches, diagnostic pin and transfer-failure guard.
 * Assumes all pins other than CLK/RST_B are asynchronous to CLK and
 * that SCLK is slow enough (several CLK periods per phase) to be sampled.
 */
`timescale 1ns/100ps
`default_nettype none
module sool_top (
    input  wire logic                              CLK,                 // system clock
    input  wire logic                              RST_B,               // sync reset, low
    input  wire logic                              OUTPUT_DISABLE_N,    // disable pin
    input  wire logic                              CS_N,                // chip select
    input  wire logic                              SCLK,                // shift clock
    input  wire logic                              SI,                  // serial data in
    input  wire logic [sool_pkg::CHANNELS-1:0]     OVERTEMP,            // per-channel hot
    input  wire logic                              SUPPLY_LOW,          // driver supply low
    input  wire logic                              INPUT_READY,         // input side stable
    input  wire logic                              XFER_STROBE,         // barrier transfer
    input  wire logic                              XFER_OK,             // transfer valid
    output var  logic [sool_pkg::CHANNELS-1:0]     POWER_OUTPUTS,       // channel drives
    output var  logic                              SO_O,                // data out level
    output var  logic                              SO_OE,               // data out enable
    output var  logic                              OVERTEMP_FLAG_N_O,   // overtemp_flag_n level
    output var  logic                              OVERTEMP_FLAG_N_OE   // overtemp_flag_n pull low
);
    import sool_pkg::*;

    typedef struct packed {
        logic [2:0]          dis_s;
        logic [2:0]          cs_s;
        logic [2:0]          clk_s;
        logic [1:0]          si_s;
        logic [1:0]          rdy_s;
        logic [1:0]          low_s;
        logic [2:0]          xs_s;
        logic [1:0]          xok_s;
        logic [CHANNELS-1:0] hot_s1;
        logic [CHANNELS-1:0] hot_s2;
        logic [7:0]          shift;
        logic [CNT_W-1:0]    cnt;
        logic                got;
        logic                so;
        logic                so_oe;
        logic                overtemp_flag_n_oe;
        logic [REJ_W-1:0]    rej;
        logic                kill;
        logic                load;
        logic [7:0]          data;
    } sool_top_type;

    sool_top_type st;
    sool_top_type next_st;

    logic                dis_act;
    logic                cs_act;
    logic                cs_rise;
    logic                cs_fall;
    logic                sck_rise;
    logic                sck_fall;
    logic                xfer_evt;
    logic                xfer_bad;
    logic                frame_ok;
    logic [CHANNELS-1:0] q;

    sool_chan_if cbus ();

    // [2] and [1] compared for edges, but disable uses [2] alone as a level; [0] feeds only [1]
    assign dis_act  = !st.dis_s[2];
    // select seen low in the same stage that flags its falling edge
    assign cs_act   = !st.cs_s[1];
    assign cs_rise  = !st.cs_s[2] & st.cs_s[1];
    assign cs_fall  = st.cs_s[2] & !st.cs_s[1];

    // shift clock and barrier strobe edges
    assign sck_rise = st.clk_s[1] & !st.clk_s[2];
    assign sck_fall = !st.clk_s[1] & st.clk_s[2];
    assign xfer_evt = st.xs_s[1] & !st.xs_s[2];
    assign xfer_bad = xfer_evt & !st.xok_s[1];

    // word complete only when clock count is a nonzero multiple of 8
    assign frame_ok = cs_rise & st.got & (st.cnt == '0);

    always_comb begin
        next_st = st;
        next_st.dis_s  = {st.dis_s[1:0], OUTPUT_DISABLE_N};
        next_st.cs_s   = {st.cs_s[1:0], CS_N};
        next_st.clk_s  = {st.clk_s[1:0], SCLK};
        next_st.si_s   = {st.si_s[0], SI};
        next_st.rdy_s  = {st.rdy_s[0], INPUT_READY};
        next_st.low_s  = {st.low_s[0], SUPPLY_LOW};
        next_st.xs_s   = {st.xs_s[1:0], XFER_STROBE};
        next_st.xok_s  = {st.xok_s[0], XFER_OK};
        next_st.hot_s1 = OVERTEMP;
        next_st.hot_s2 = st.hot_s1;
        next_st.load   = 1'b0;

        // diagnostic pulls low on any hot channel or low supply
        next_st.overtemp_flag_n_oe = (|st.hot_s2) | st.low_s[1];

        // consecutive rejected barrier transfers
        if (xfer_evt) begin
            if (st.xok_s[1]) begin
                next_st.rej  = '0;
                next_st.kill = 1'b0;
            end else if (st.rej != REJECT_LIMIT) begin
                next_st.rej  = st.rej + 3'h1;
                next_st.kill = (st.rej + 3'h1) == REJECT_LIMIT;
            end
        end

        // select low: count clocks, move the shifter
        if (cs_act) begin
            if (cs_fall) begin
                next_st.cnt = '0;
                next_st.got = 1'b0;
                next_st.so  = st.shift[7];
            end
            if (sck_rise) begin
                next_st.shift = {st.shift[6:0], st.si_s[1]};
                next_st.cnt   = st.cnt + 3'h1;
                next_st.got   = 1'b1;
            end
            if (sck_fall) begin
                next_st.so = st.shift[7];
            end
        end
        // driver enable follows synced select
        next_st.so_oe = !st.cs_s[1];

        // a valid word ends the off state
        if (frame_ok) begin
            next_st.load = 1'b1;
            next_st.data = st.shift;
            // a reject in the same cycle wins over the clear
            if (!xfer_bad) begin
                next_st.kill = 1'b0;
                next_st.rej  = '0;
            end
        end

        // disable aborts any frame and clears the shifter
        if (dis_act) begin
            next_st.shift = SHIFT_RESET;
            next_st.cnt   = '0;
            next_st.got   = 1'b0;
            next_st.load  = 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            st.dis_s   <= SYNC_RESET;
            st.cs_s    <= 3'h7;
            st.clk_s   <= 3'h7;
            st.si_s    <= 2'h0;
            st.rdy_s   <= 2'h0;
            st.low_s   <= 2'h0;
            st.xs_s    <= SYNC_RESET;
            st.xok_s   <= 2'h0;
            st.hot_s1  <= '0;
            st.hot_s2  <= '0;
            st.shift   <= SHIFT_RESET;
            st.cnt     <= '0;
            st.got     <= 1'b0;
            st.so      <= SO_RESET;
            st.so_oe   <= 1'b0;
            st.overtemp_flag_n_oe <= 1'b0;
            st.rej     <= '0;
            st.kill    <= 1'b0;
            st.load    <= 1'b0;
            st.data    <= SHIFT_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign cbus.clk   = CLK;
    assign cbus.rst_b = RST_B;
    assign cbus.dis_n = OUTPUT_DISABLE_N;
    assign cbus.load  = st.load;
    assign cbus.data  = st.data;
    assign cbus.allow = st.rdy_s[1] & !st.kill;

    for (genvar i = 0; i < CHANNELS; i++) begin : g_chan
        sool_chan #(
            .IDX (i)
        ) u_chan (
            .bus (cbus.chan),
            .q   (q[i])
        );
    end

    assign POWER_OUTPUTS      = q;
    assign SO_O               = st.so;
    assign SO_OE              = st.so_oe;
    assign OVERTEMP_FLAG_N_O  = 1'b0;
    assign OVERTEMP_FLAG_N_OE = st.overtemp_flag_n_oe;
endmodule // sool_top
`default_nettype wire

// ==== bench/sool_top_monitor.sv ====
/* Checker for the octal latch pins.
   Assumes it is bound to sool_top. */
`timescale 1ns/100ps
`default_nettype none
module sool_top_monitor (
    input wire logic       CLK,                // clock
    input wire logic       RST_B,              // reset
    input wire logic       OUTPUT_DISABLE_N,   // disable
    input wire logic       CS_N,               // select
    input wire logic       SCLK,               // shift clock
    input wire logic [7:0] OVERTEMP,           // hot
    input wire logic       SUPPLY_LOW,         // supply low
    input wire logic       INPUT_READY,        // ready
    input wire logic [7:0] POWER_OUTPUTS,      // drives
    input wire logic       SO_O,               // data out
    input wire logic       SO_OE,              // data out enable
    input wire logic       OVERTEMP_FLAG_N_O,  // overtemp_flag_n level
    input wire logic       OVERTEMP_FLAG_N_OE  // overtemp_flag_n enable
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    a_dis_off: assert property (
        !OUTPUT_DISABLE_N |-> POWER_OUTPUTS == 8'h00) else $error("on while disabled");
    a_ready_gate: assert property (
        !INPUT_READY [*5] |-> POWER_OUTPUTS == 8'h00) else $error("on while not ready");
    a_out_quiet: assert property (
        !CS_N [*6] |-> $stable(POWER_OUTPUTS) || POWER_OUTPUTS == 8'h00)
        else $error("outputs moved while selected");
    a_so_hiz: assert property (
        CS_N [*5] |-> !SO_OE) else $error("data out driven while idle");
    a_so_drive: assert property (
        !CS_N [*5] |-> SO_OE) else $error("data out not driven");
    a_so_fall: assert property (
        $changed(SO_O) && SO_OE && $past(SO_OE, 2)
        |-> !($past(SCLK, 3) && $past(SCLK, 4) && $past(SCLK, 5)))
        else $error("data out moved without falling clock");
    a_overtemp_flag_n_set: assert property (
        ((|OVERTEMP) || SUPPLY_LOW) [*5] |-> OVERTEMP_FLAG_N_OE) else $error("overtemp_flag_n missed");
    a_overtemp_flag_n_clear: assert property (
        (!(|OVERTEMP) && !SUPPLY_LOW) [*5] |-> !OVERTEMP_FLAG_N_OE) else $error("overtemp_flag_n stuck");
    a_overtemp_flag_n_pin: assert property (
        OVERTEMP_FLAG_N_O == 1'b0) else $error("overtemp_flag_n level not low");
endmodule // sool_top_monitor
bind sool_top sool_top_monitor u_mon (.CLK(CLK), .RST_B(RST_B),
    .OUTPUT_DISABLE_N(OUTPUT_DISABLE_N), .CS_N(CS_N), .SCLK(SCLK), .OVERTEMP(OVERTEMP),
    .SUPPLY_LOW(SUPPLY_LOW), .INPUT_READY(INPUT_READY), .POWER_OUTPUTS(POWER_OUTPUTS),
    .SO_O(SO_O), .SO_OE(SO_OE), .OVERTEMP_FLAG_N_O(OVERTEMP_FLAG_N_O),
    .OVERTEMP_FLAG_N_OE(OVERTEMP_FLAG_N_OE));
`default_nettype wire

// ==== bench/sool_master.sv ====
/* Serial master model driving select, shift clock and data in.
   Assumes the bench clock; changes its pins on its rising edge. */
`timescale 1ns/100ps
`default_nettype none
module sool_master (
    input  wire logic CLK,   // bench clock
    input  wire logic SO,    // data out seen
    output var  logic CS_N,  // select
    output var  logic SCLK,  // shift clock
    output var  logic SI     // data in
);
    initial begin
        CS_N = 1'b1;
        SCLK = 1'b1;
        SI   = 1'b0;
    end
    task automatic frame(input int n, input logic [15:0] d, output logic [15:0] q);
        q = 16'h0000;
        repeat (2) @(posedge CLK);
        CS_N <= 1'b0;
        repeat (8) @(posedge CLK);
        for (int i = n - 1; i >= 0; i--) begin
            SCLK <= 1'b0;
            SI   <= d[i];
            repeat (8) @(posedge CLK);
            SCLK <= 1'b1;
            q = {q[14:0], SO};
            repeat (8) @(posedge CLK);
        end
        CS_N <= 1'b1;
        SI   <= ~SI;
        repeat (8) @(posedge CLK);
    endtask
endmodule // sool_master
`default_nettype wire

// ==== bench/test_serial_octal_output_latch.sv ====
/* Bench for the serial octal output latch.
   Assumes sool_top, its package and the master model. */
`timescale 1ns/100ps
`default_nettype none
module test_serial_octal_output_latch;
    import sool_pkg::*;
    logic        clk, rst_b, dis_n, sup_low, ready, xs, xok, so_o, so_oe, fl_o, fl_oe;
    logic        cs_n, sclk, si;
    logic [7:0]  hot, pw;
    logic [15:0] q;
    wire         so_w = so_oe ? so_o : 1'bz;
    int          errors, checked;
    sool_master m (.CLK(clk), .SO(so_w), .CS_N(cs_n), .SCLK(sclk), .SI(si));
    sool_top uut (.CLK(clk), .RST_B(rst_b), .OUTPUT_DISABLE_N(dis_n), .CS_N(cs_n),
        .SCLK(sclk), .SI(si), .OVERTEMP(hot), .SUPPLY_LOW(sup_low), .INPUT_READY(ready),
        .XFER_STROBE(xs), .XFER_OK(xok), .POWER_OUTPUTS(pw), .SO_O(so_o), .SO_OE(so_oe),
        .OVERTEMP_FLAG_N_O(fl_o), .OVERTEMP_FLAG_N_OE(fl_oe));
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        checked++;
        if (s !== e) begin
            errors++;
            $display("BAD %0t seen %h want %h", $time, s, e);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic strobe(input logic ok);
        xok <= ok;
        @(posedge clk);
        xs <= 1'b1;
        repeat (4) @(posedge clk);
        xs <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic t_words;
        m.frame(8, 16'h00a5, q);
        chk({8'h00, pw}, 16'h00a5);
        m.frame(16, 16'h3cc3, q);
        chk({8'h00, pw}, 16'h00c3);
        chk(q, 16'ha53c);
        m.frame(7, 16'h007f, q);
        chk({8'h00, pw}, 16'h00c3);
        m.frame(0, 16'h0000, q);
        chk({8'h00, pw}, 16'h00c3);
        $display("words done");
    endtask
    task automatic t_disable;
        dis_n <= 1'b0;
        #1 chk({8'h00, pw}, 16'h0000);
        repeat (6) @(posedge clk);
        dis_n <= 1'b1;
        repeat (20) @(posedge clk);
        chk({8'h00, pw}, 16'h0000);
        m.frame(16, 16'h0081, q);
        chk(q, 16'h0000);
        chk({8'h00, pw}, 16'h0081);
        $display("disable done");
    endtask
    task automatic t_gates;
        ready <= 1'b0;
        repeat (6) @(posedge clk);
        chk({8'h00, pw}, 16'h0000);
        ready <= 1'b1;
        repeat (6) @(posedge clk);
        repeat (4) strobe(1'b0);
        chk({8'h00, pw}, 16'h0000);
        strobe(1'b1);
        chk({8'h00, pw}, 16'h0081);
        $display("gates done");
    endtask
    task automatic t_overtemp_flag_n;
        for (int i = 0; i < 9; i++) begin
            hot     <= (i < 8) ? 8'h01 << i : 8'h00;
            sup_low <= (i == 8);
            repeat (6) @(posedge clk);
            chk({15'h0000, fl_oe}, 16'h0001);
        end
        sup_low <= 1'b0;
        repeat (6) @(posedge clk);
        chk({14'h0000, fl_oe, fl_o}, 16'h0000);
        $display("overtemp_flag_n done");
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        {rst_b, sup_low, xs, hot} = '0;
        {dis_n, ready, xok} = 3'h7;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        repeat (6) @(posedge clk);
        t_words();
        t_disable();
        t_gates();
        t_overtemp_flag_n();
        finish_test();
    end
endmodule // test_serial_octal_output_latch
`default_nettype wire
